// file: hdl/ofrc_pkg.sv
// Purpose: shared constants for the output frame and range configuration block
// Assumes: 32-bit AXI4-Lite register access, byte addresses as printed
// Notes:   reserved bits are masked out on write and read back as zero
package ofrc_pkg;
    // ==========================================================
    // register map
    localparam int          AXI_ADDR_W     = 8;
    localparam int          AXI_DATA_W     = 32;
    localparam logic [7:0]  OFC_ADDR       = 8'h10;
    localparam logic [7:0]  RSEL_ADDR      = 8'h14;
    localparam logic [31:0] OFC_RESET      = 32'h0000_0000;
    localparam logic [31:0] RSEL_RESET     = 32'h0000_0000;
    localparam logic [31:0] OFC_WMASK      = 32'h0000_0d0f;
    localparam logic [31:0] RSEL_WMASK     = 32'h0000_004f;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    // ==========================================================
    // field positions
    localparam int          OFC_ALARM_HI   = 10;
    localparam int          OFC_ALARM_LO   = 11;
    localparam int          OFC_RANGE_INC  = 8;
    localparam int          OFC_PARITY     = 3;
    localparam int          OFC_SRC_MSB    = 2;
    localparam int          OFC_SRC_LSB    = 0;
    localparam int          RSEL_REF_OFF   = 6;
    localparam int          RANGE_W        = 4;
    localparam int          UNIPOLAR_BIT   = 3;
    // ==========================================================
    // output value sources
    localparam logic [2:0]  SRC_ZEROS      = 3'b100;
    localparam logic [2:0]  SRC_ONES       = 3'b101;
    localparam logic [2:0]  SRC_ALT1       = 3'b110;
    localparam logic [2:0]  SRC_ALT2       = 3'b111;
    // ==========================================================
    // frame geometry
    localparam int          DATA_W_DEF     = 16;
    localparam int          FIFO_DEPTH_DEF = 8;
    localparam int          ALARM_BITS     = 2;
    localparam int          PARITY_BITS    = 2;
    localparam int          HIGHEST_BIPOLAR = 4;
    localparam int          HIGHEST_UNIPOLAR = 11;
    localparam int          LOWEST_UNIPOLAR = 8;

    typedef enum logic [1:0] {
        OFRC_IDLE  = 2'b00,
        OFRC_SHIFT = 2'b01
    } ofrc_ser_t;
endpackage : ofrc_pkg

// file: hdl/ofrc_top.sv
// Purpose: output frame content and input range configuration with frame builder
// Assumes: conversion words arrive on a valid/ready stream, alarm flags are live levels
// Notes:   one frame bit leaves per cycle in which serial_advance is high
//
// What this block does
// - alarm select field appends high/low input flags
// - reserved bits read zero, writes ignored
// - range bit appends the 4-bit range code
// - parity bit appends two parity LSBs
// - result parity is even over result only
// - frame parity is even over the frame bits except result parity
// - result parity excluded from frame parity
// - parity adds two bits shifted out
// - source top bit clear sends conversion result
// - source codes 100-111 send fixed patterns
// - reference off bit disables internal reference
// - codes 0000-0100 select five bipolar ranges
// - codes 1000-1011 select four unipolar ranges
// - range register bytes at 14h to 17h
// - high flag is live alarm condition
`timescale 1ns/1ps

// ==========================================================
// fifo in the conversion data path
module ofrc_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    initial begin
        if (D < 2 || (D & (D - 1)) != 0) begin
            $error("fifo depth must be a power of two of at least 2");
        end
    end

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wr_ptr;
        logic [PW-1:0]       rd_ptr;
        logic [CW-1:0]       count;
        logic                ready;
        logic                valid;
    } ofrc_fifo_t;

    ofrc_fifo_t s_reg;
    ofrc_fifo_t s_next;
    logic       push;
    logic       pop;

    assign push      = in_valid && s_reg.ready;
    assign pop       = out_ready && s_reg.valid;
    assign in_ready  = s_reg.ready;
    assign out_valid = s_reg.valid;
    assign out_data  = s_reg.mem[s_reg.rd_ptr];

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr_ptr] = in_data;
            s_next.wr_ptr            = s_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            s_next.count = s_reg.count + 1'b1;
        end else if (pop && !push) begin
            s_next.count = s_reg.count - 1'b1;
        end
        // registered flags keep ready and valid glitch free
        s_next.ready = (s_next.count != CW'(D));
        s_next.valid = (s_next.count != '0);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg       <= '0;
            s_reg.ready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : ofrc_fifo

// ==========================================================
// top: register bank, frame builder, serializer
module ofrc_top #(
    parameter int DATA_W     = ofrc_pkg::DATA_W_DEF,
    parameter int FIFO_DEPTH = ofrc_pkg::FIFO_DEPTH_DEF
) (
    input  wire logic                               aclk,
    input  wire logic                               aresetn,
    input  wire logic [ofrc_pkg::AXI_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    input  wire logic [ofrc_pkg::AXI_DATA_W-1:0]    s_axi_wdata,
    input  wire logic [3:0]                         s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    output logic [1:0]                              s_axi_bresp,
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    input  wire logic [ofrc_pkg::AXI_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    output logic [ofrc_pkg::AXI_DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                              s_axi_rresp,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    input  wire logic [DATA_W-1:0]                  conv_data,
    input  wire logic                               conv_valid,
    output logic                                    conv_ready,
    input  wire logic                               alarm_in_high,
    input  wire logic                               alarm_in_low,
    input  wire logic                               serial_advance,
    output logic                                    serial_output_lines,
    output logic                                    serial_bit_valid,
    output logic                                    serial_frame_last,
    output logic                                    internal_reference_off,
    output logic [ofrc_pkg::RANGE_W-1:0]            range_code,
    output logic                                    range_unipolar,
    output logic                                    range_code_legal
);
    import ofrc_pkg::*;

    localparam int FRAME_MAX = DATA_W + ALARM_BITS + RANGE_W + PARITY_BITS;
    localparam int LEN_W     = $clog2(FRAME_MAX + 1);

    initial begin
        if (DATA_W < 2 || DATA_W > 64) begin
            $error("conversion width out of range");
        end
    end

    typedef struct packed {
        logic [31:0]           ctl_reg;
        logic [31:0]           rsel_reg;
        logic                  aw_held;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic                  w_held;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        ofrc_ser_t             st;
        logic [FRAME_MAX-1:0]  sh;
        logic [LEN_W-1:0]      cnt;
        logic                  out_bit;
        logic                  bit_valid;
        logic                  last;
        logic                  ref_off;
        logic [RANGE_W-1:0]    range;
        logic                  unipolar;
        logic                  legal;
    } ofrc_state_t;

    ofrc_state_t          s_reg;
    ofrc_state_t          s_next;
    logic [DATA_W-1:0]    fifo_data;
    logic                 fifo_valid;
    logic                 load;
    logic                 wr_en;
    logic [DATA_W-1:0]    value;
    logic [FRAME_MAX-1:0] frame_rj;
    logic [LEN_W-1:0]     frame_len;
    logic                 data_par;
    logic                 frame_par;

    ofrc_fifo #(
        .W (DATA_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_data   (conv_data),
        .in_valid  (conv_valid),
        .in_ready  (conv_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (load)
    );

    // ==========================================================
    // frame builder
    assign load  = fifo_valid && (s_reg.st == OFRC_IDLE);
    assign wr_en = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;

    always_comb begin
        value = fifo_data;
        unique case (s_reg.ctl_reg[OFC_SRC_MSB:OFC_SRC_LSB])
            SRC_ZEROS: value = '0;
            SRC_ONES:  value = '1;
            SRC_ALT1: begin
                for (int i = 0; i < DATA_W; i++) value[i] = ~i[0];
            end
            SRC_ALT2: begin
                for (int i = 0; i < DATA_W; i++) value[i] = ~i[1];
            end
            default: value = fifo_data;
        endcase
    end

    always_comb begin
        frame_rj  = FRAME_MAX'(value);
        frame_len = LEN_W'(DATA_W);
        data_par  = ^value;
        frame_par = ^value;
        // flags are sampled live when the frame is built
        if (s_reg.ctl_reg[OFC_ALARM_HI]) begin
            frame_rj  = {frame_rj[FRAME_MAX-2:0], alarm_in_high};
            frame_len = frame_len + 1'b1;
            frame_par = frame_par ^ alarm_in_high;
        end
        if (s_reg.ctl_reg[OFC_ALARM_LO]) begin
            frame_rj  = {frame_rj[FRAME_MAX-2:0], alarm_in_low};
            frame_len = frame_len + 1'b1;
            frame_par = frame_par ^ alarm_in_low;
        end
        if (s_reg.ctl_reg[OFC_RANGE_INC]) begin
            frame_rj  = {frame_rj[FRAME_MAX-RANGE_W-1:0], s_reg.range};
            frame_len = frame_len + LEN_W'(RANGE_W);
            frame_par = frame_par ^ (^s_reg.range);
        end
        if (s_reg.ctl_reg[OFC_PARITY]) begin
            // result parity stays out of the frame parity sum
            frame_rj  = {frame_rj[FRAME_MAX-3:0], data_par, frame_par};
            frame_len = frame_len + LEN_W'(PARITY_BITS);
        end
    end

    // ==========================================================
    // next state: bus slave and serializer
    always_comb begin
        logic [31:0] bmask;
        logic [31:0] merged;
        bmask  = '0;
        merged = '0;
        s_next = s_reg;
        for (int b = 0; b < 4; b++) bmask[b*8 +: 8] = {8{s_reg.wstrb[b]}};
        // aw and w may arrive in either order
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_held = 1'b1;
            s_next.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_held = 1'b1;
            s_next.wdata  = s_axi_wdata;
            s_next.wstrb  = s_axi_wstrb;
        end
        if (wr_en) begin
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = RESP_OKAY;
            // byte lanes map onto consecutive byte addresses
            if (s_reg.awaddr[AXI_ADDR_W-1:2] == OFC_ADDR[AXI_ADDR_W-1:2]) begin
                merged        = (s_reg.ctl_reg & ~bmask) | (s_reg.wdata & bmask);
                s_next.ctl_reg = merged & OFC_WMASK;
            end else if (s_reg.awaddr[AXI_ADDR_W-1:2] == RSEL_ADDR[AXI_ADDR_W-1:2]) begin
                merged         = (s_reg.rsel_reg & ~bmask) | (s_reg.wdata & bmask);
                s_next.rsel_reg = merged & RSEL_WMASK;
            end else begin
                s_next.bresp = RESP_SLVERR;
            end
        end else if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready  = !s_next.w_held && !s_next.bvalid;

        if (s_axi_arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = RESP_OKAY;
            if (s_axi_araddr[AXI_ADDR_W-1:2] == OFC_ADDR[AXI_ADDR_W-1:2]) begin
                s_next.rdata = s_reg.ctl_reg & OFC_WMASK;
            end else if (s_axi_araddr[AXI_ADDR_W-1:2] == RSEL_ADDR[AXI_ADDR_W-1:2]) begin
                s_next.rdata = s_reg.rsel_reg & RSEL_WMASK;
            end else begin
                s_next.rdata = '0;
                s_next.rresp = RESP_SLVERR;
            end
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        s_next.arready = !s_next.rvalid;

        s_next.ref_off  = s_next.rsel_reg[RSEL_REF_OFF];
        s_next.range    = s_next.rsel_reg[RANGE_W-1:0];
        s_next.unipolar = s_next.rsel_reg[UNIPOLAR_BIT];
        s_next.legal    = (s_next.range <= RANGE_W'(HIGHEST_BIPOLAR)) ||
                          (s_next.range >= RANGE_W'(LOWEST_UNIPOLAR) &&
                           s_next.range <= RANGE_W'(HIGHEST_UNIPOLAR));

        s_next.bit_valid = 1'b0;
        s_next.last      = 1'b0;
        unique case (s_reg.st)
            OFRC_IDLE: begin
                if (load) begin
                    s_next.sh  = frame_rj << (LEN_W'(FRAME_MAX) - frame_len);
                    s_next.cnt = frame_len;
                    s_next.st  = OFRC_SHIFT;
                end
            end
            OFRC_SHIFT: begin
                // the reader may pause the frame at any bit
                if (serial_advance) begin
                    s_next.out_bit   = s_reg.sh[FRAME_MAX-1];
                    s_next.bit_valid = 1'b1;
                    s_next.sh        = {s_reg.sh[FRAME_MAX-2:0], 1'b0};
                    s_next.cnt       = s_reg.cnt - 1'b1;
                    if (s_reg.cnt == LEN_W'(1)) begin
                        s_next.last = 1'b1;
                        s_next.st   = OFRC_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg          <= '0;
            s_reg.ctl_reg  <= OFC_RESET;
            s_reg.rsel_reg <= RSEL_RESET;
            s_reg.awready  <= 1'b1;
            s_reg.wready   <= 1'b1;
            s_reg.arready  <= 1'b1;
            s_reg.legal    <= 1'b1;
            s_reg.st       <= OFRC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready          = s_reg.awready;
    assign s_axi_wready           = s_reg.wready;
    assign s_axi_bvalid           = s_reg.bvalid;
    assign s_axi_bresp            = s_reg.bresp;
    assign s_axi_arready          = s_reg.arready;
    assign s_axi_rvalid           = s_reg.rvalid;
    assign s_axi_rdata            = s_reg.rdata;
    assign s_axi_rresp            = s_reg.rresp;
    assign serial_output_lines    = s_reg.out_bit;
    assign serial_bit_valid       = s_reg.bit_valid;
    assign serial_frame_last      = s_reg.last;
    assign internal_reference_off = s_reg.ref_off;
    assign range_code             = s_reg.range;
    assign range_unipolar         = s_reg.unipolar;
    assign range_code_legal       = s_reg.legal;

    // ==========================================================
    // checks
    a_alarm_high_lsb: assert property (@(posedge aclk) disable iff (!aresetn)
        load && s_reg.ctl_reg[11:8] == 4'h4 && !s_reg.ctl_reg[OFC_PARITY] |-> frame_rj[0] == alarm_in_high)
        else $error("high alarm flag not at frame end");
    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> (s_axi_rdata & ~(OFC_WMASK | RSEL_WMASK)) == '0)
        else $error("reserved bits read nonzero");
    a_range_append: assert property (@(posedge aclk) disable iff (!aresetn)
        load && s_reg.ctl_reg[OFC_RANGE_INC] && !s_reg.ctl_reg[OFC_PARITY] |-> frame_rj[3:0] == s_reg.range)
        else $error("range code missing from frame");
    a_result_parity: assert property (@(posedge aclk) disable iff (!aresetn)
        load && s_reg.ctl_reg[OFC_PARITY] |-> frame_rj[1] == ^value)
        else $error("result parity wrong");
    a_frame_parity: assert property (@(posedge aclk) disable iff (!aresetn)
        load && s_reg.ctl_reg[OFC_PARITY] |-> ((^(frame_rj >> 2)) ^ frame_rj[0]) == 1'b0)
        else $error("frame parity not even");
    a_parity_length: assert property (@(posedge aclk) disable iff (!aresetn)
        load && s_reg.ctl_reg[11:8] == 4'h0 && s_reg.ctl_reg[OFC_PARITY] |=> s_reg.cnt == LEN_W'(DATA_W + 2))
        else $error("parity frame length wrong");
    a_source_live: assert property (@(posedge aclk) disable iff (!aresetn)
        load && !s_reg.ctl_reg[OFC_SRC_MSB] |-> value == fifo_data)
        else $error("conversion result not passed through");
    a_source_ones: assert property (@(posedge aclk) disable iff (!aresetn)
        load && s_reg.ctl_reg[2:0] == SRC_ONES |-> &value)
        else $error("all ones pattern wrong");
    a_ref_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && s_reg.awaddr == RSEL_ADDR && s_reg.wstrb[0] |-> ##2 internal_reference_off == $past(s_reg.wdata[6], 2))
        else $error("reference off not following write");
endmodule : ofrc_top

// file: verif/ofrc_host_model.sv
// Purpose: host reading the serial output frame, one bit per advance
// Assumes: frames are at most 32 bits long
// Notes:   stall throttles advance to one cycle in four so the fifo fills
`timescale 1ns/1ps
// ==========================================================
// host side reader
module ofrc_host_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        stall,
    input  wire logic        serial_output_lines,
    input  wire logic        serial_bit_valid,
    input  wire logic        serial_frame_last,
    output logic             serial_advance,
    output logic [31:0]      frame_word,
    output logic [5:0]       frame_len,
    output logic             frame_done
);
    logic [31:0] sh;
    logic [5:0]  n;
    logic [1:0]  cnt;
    always_ff @(posedge aclk) begin
        frame_done <= 1'b0;
        serial_advance <= aresetn && (!stall || cnt == 2'h3);
        cnt <= cnt + 2'h1;
        if (!aresetn) begin
            cnt <= 2'h0;
            n <= 6'h0;
            sh <= 32'h0;
        end else if (serial_bit_valid) begin
            // parity bits are clocked in like any other
            sh <= serial_frame_last ? 32'h0 : {sh[30:0], serial_output_lines};
            n <= serial_frame_last ? 6'h0 : n + 6'h1;
            frame_word <= {sh[30:0], serial_output_lines};
            frame_len <= n + 6'h1;
            frame_done <= serial_frame_last;
        end
    end
endmodule : ofrc_host_model

// file: verif/ofrc_top_tb_top.sv
// Purpose: self-checking bench for the frame and range configuration block
// Assumes: host model drains frames, bench is the register master
// Notes:   frames are predicted at push time, config is held steady meanwhile
`timescale 1ns/1ps
module ofrc_top_tb_top;
    import ofrc_pkg::*;
    typedef struct packed {logic [31:0] w; logic [5:0] l;} ofrc_exp_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, conv_valid;
    logic alarm_in_high, alarm_in_low, stall;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, ctl;
    logic [3:0]  s_axi_wstrb, rng;
    logic [15:0] conv_data;
    logic [16:0] lf;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_ready, serial_advance;
    wire logic serial_output_lines, serial_bit_valid, serial_frame_last, internal_reference_off, fdone;
    wire logic range_unipolar, range_code_legal;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata, fword;
    wire logic [3:0]  range_code;
    wire logic [5:0]  flen;
    int n_errors, n_compared, i, j;
    ofrc_exp_t q[$];
    ofrc_top #(.DATA_W(16), .FIFO_DEPTH(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .conv_data, .conv_valid, .conv_ready, .alarm_in_high, .alarm_in_low, .serial_advance, .serial_output_lines,
        .serial_bit_valid, .serial_frame_last, .internal_reference_off, .range_code, .range_unipolar,
        .range_code_legal);
    ofrc_host_model host (.aclk, .aresetn, .stall, .serial_output_lines, .serial_bit_valid, .serial_frame_last,
        .serial_advance, .frame_word(fword), .frame_len(flen), .frame_done(fdone));
    // ==========================================================
    // helpers
    function automatic logic [16:0] nxt(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : nxt
    function automatic ofrc_exp_t mk(input logic [15:0] v, input logic [31:0] c, input logic [3:0] r,
                                     input logic h, input logic l);
        ofrc_exp_t e;
        logic [15:0] s;
        s = !c[2] ? v : c[1:0] == 2'h0 ? 16'h0000 : c[1:0] == 2'h1 ? 16'hffff : c[1:0] == 2'h2 ? 16'h5555 : 16'h3333;
        e.w = {16'h0000, s};
        e.l = 6'h10;
        if (c[10]) e = {e.w[30:0], h, e.l + 6'h1};
        if (c[11]) e = {e.w[30:0], l, e.l + 6'h1};
        if (c[8]) e = {e.w[27:0], r, e.l + 6'h4};
        if (c[3]) e = {e.w[29:0], ^s, ^e.w, e.l + 6'h2};
        return e;
    endfunction : mk
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic tmo(input string m);
        n_errors++;
        $display("CHECK FAILED at %0t: timeout in %s", $time, m);
        conclude();
    endtask : tmo
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (k == 64) tmo("write");
        check(32'(s_axi_bresp), 32'(er), "write response");
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (k == 64) tmo("read");
        check(s_axi_rdata, d, "read data");
        check(32'(s_axi_rresp), 32'(er), "read response");
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic push;
        int k;
        lf = nxt(lf);
        q.push_back(mk(lf[15:0], ctl, rng, alarm_in_high, alarm_in_low));
        @(posedge aclk);
        conv_data <= lf[15:0];
        conv_valid <= 1'b1;
        for (k = 0; k < 2000; k++) begin
            @(posedge aclk);
            if (conv_ready) break;
        end
        if (k == 2000) tmo("push");
        conv_valid <= 1'b0;
    endtask : push
    task automatic drain;
        int k;
        for (k = 0; k < 4000 && q.size() > 0; k++) @(posedge aclk);
        if (k == 4000) tmo("drain");
    endtask : drain
    // ==========================================================
    // frame scoreboard
    always @(posedge aclk) begin
        if (fdone && q.size() == 0) check(32'h1, 32'h0, "unexpected frame");
        else if (fdone) begin
            check(fword, q[0].w, "frame bits");
            check(32'(flen), 32'(q[0].l), "frame length");
            void'(q.pop_front());
        end
    end
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // ==========================================================
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, conv_valid} = '0;
        {alarm_in_high, alarm_in_low, stall, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, conv_data} = '0;
        {ctl, rng} = '0;
        lf = 17'h11ec1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axr(OFC_ADDR, 32'h0, RESP_OKAY);
        axr(RSEL_ADDR, 32'h0, RESP_OKAY);
        axw(8'h18, 32'hffffffff, 4'hf, RESP_SLVERR);
        axr(8'h18, 32'h0, RESP_SLVERR);
        axw(OFC_ADDR, 32'hffffffff, 4'hf, RESP_OKAY);
        axr(OFC_ADDR, 32'h00000d0f, RESP_OKAY);
        axw(RSEL_ADDR, 32'hffffffff, 4'he, RESP_OKAY);
        axr(RSEL_ADDR, 32'h0, RESP_OKAY);
        $display("test registers done");
        for (i = 0; i < 16; i++) begin
            axw(RSEL_ADDR, {25'h0, i[0], 2'h0, i[3:0]}, 4'h1, RESP_OKAY);
            repeat (2) @(posedge aclk);
            check(32'(range_code), 32'(i[3:0]), "range code");
            check(32'(range_unipolar), 32'(i[3]), "unipolar");
            check(32'(range_code_legal), 32'(i <= 4 || (i >= 8 && i <= 11)), "legal code");
            check(32'(internal_reference_off), 32'(i[0]), "reference off");
        end
        $display("test range codes done");
        // each source code twice, with random fields and reserved bits set
        for (i = 0; i < 16; i++) begin
            lf = nxt(lf);
            ctl = ({lf[14:0], lf} & 32'hfffffff8) | 32'(i[2:0]);
            // second pass pins flag, range and parity fields
            if (i[3]) ctl[11:3] = {i[1:0] == 2'h1 ? 4'h4 : i[1:0] == 2'h2 ? 4'h1 : 4'h0, 4'h0, i[1:0] == 2'h0};
            rng = lf[5] ? {2'h2, lf[1:0]} : 4'(lf[2:0] % 3'h5);
            axw(OFC_ADDR, ctl, 4'hf, RESP_OKAY);
            axw(RSEL_ADDR, 32'(rng), 4'h1, RESP_OKAY);
            alarm_in_high <= lf[7];
            alarm_in_low <= lf[8];
            stall <= lf[9];
            repeat (3) @(posedge aclk);
            for (j = 0; j < 2; j++) push();
            drain();
        end
        $display("test frames done");
        stall <= 1'b1;
        for (j = 0; j < 9; j++) push();
        @(posedge aclk);
        check(32'(conv_ready), 32'h0, "fifo full");
        stall <= 1'b0;
        drain();
        $display("test fifo fill done");
        conclude();
    end
endmodule : ofrc_top_tb_top
